// File: hw/swc_ctrl.sv
/*
  swc_ctrl: sleep and wake-up controller.  Holds the power-down and time-out
  flags, gates the instruction clock, freezes I/O drive, clears the watchdog
  and decides how the core resumes.  Assumes the core pulses HALT_EXEC and
  WDCLR_EXEC for one cycle, that interrupt enables and flags come from core
  logic on CORE_CLK, and that the master clear pin and watchdog time-out
  arrive asynchronously.
*/
`timescale 1ns/1ps
module swc_ctrl
  import swc_pkg::*;
#(
  parameter int NSRC = SWC_NSRC
)(
  input  wire logic            CORE_CLK,
  input  wire logic            SRST,
  input  wire logic            CLK_EN,
  input  wire logic            POR,
  input  wire logic            HALT_EXEC,
  input  wire logic            WDCLR_EXEC,
  input  wire logic            WDOG_ENABLE,
  input  wire logic            PSA_TO_WDOG,
  input  wire logic            WDOG_TIMEOUT,
  input  wire logic            MASTER_CLEAR_PIN_N,
  input  wire logic            GLOBAL_IRQ_ENABLE,
  input  wire logic [NSRC-1:0] IRQ_ENABLE,
  input  wire logic [NSRC-1:0] IRQ_FLAG,
  input  wire logic [12:0]     HALT_PC,
  input  wire logic [7:0]      PORT_OUT,
  input  wire logic [7:0]      PORT_OE_N,
  output logic                 POWER_DOWN_FLAG,
  output logic                 TIMEOUT_FLAG,
  output logic                 SLEEPING,
  output logic                 OSC_DRV_EN,
  output logic                 INSTR_CLK_EN,
  output logic                 WDOG_CLEAR,
  output logic                 PRESCALE_CLEAR,
  output logic                 DEV_RESET,
  output logic                 MASTER_CLEAR_PIN_DRIVE_OE_N,
  output logic                 RESUME,
  output logic                 VECTOR_REQ,
  output logic [12:0]          VECTOR_ADDR,
  output logic [12:0]          PREFETCH_ADDR,
  output logic [7:0]           PIN_OUT,
  output logic [7:0]           PIN_OE_N,
  output swc_cause_t           WAKE_CAUSE
);

  // two-stage synchronisers for the asynchronous inputs
  logic       master_clear_pin_s1;
  logic       master_clear_pin_s2;
  logic       wto_s1;
  logic       wto_s2;
  logic       wto_d;
  logic       sleep;
  logic       pend_vec;
  swc_flags_t flags;
  swc_core_t  core_req;

  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      master_clear_pin_s1 <= 1'b1;
      master_clear_pin_s2 <= 1'b1;
      wto_s1  <= 1'b0;
      wto_s2  <= 1'b0;
      wto_d   <= 1'b0;
    end
    else if (CLK_EN)
    begin
      master_clear_pin_s1 <= MASTER_CLEAR_PIN_N;
      master_clear_pin_s2 <= master_clear_pin_s1;
      wto_s1  <= WDOG_TIMEOUT;
      wto_s2  <= wto_s1;
      wto_d   <= wto_s2;
    end
  end

  // decoded events
  logic master_clear_pin_low;
  logic wto_evt;
  logic pending;
  logic halt_full;
  logic halt_nop;
  logic wake_irq;
  logic wake_any;

  assign master_clear_pin_low  = !master_clear_pin_s2;
  assign wto_evt   = wto_s2 && !wto_d && WDOG_ENABLE;
  // only the six sleep-capable sources are wired in; each needs its enable
  assign pending   = |(IRQ_ENABLE & IRQ_FLAG);
  // a flag already pending turns the halt into a no-op
  assign halt_nop  = HALT_EXEC && !sleep && pending;
  assign halt_full = HALT_EXEC && !sleep && !pending;
  assign wake_irq  = sleep && pending;
  assign wake_any  = sleep && (wake_irq || wto_evt || master_clear_pin_low);

  // power-down state flag; gates clocks and the oscillator driver
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
      sleep <= 1'b0;
    else if (CLK_EN)
    begin
      if (master_clear_pin_low || wake_any)
        sleep <= 1'b0;
      else if (halt_full)
        sleep <= 1'b1;
    end
  end

  // clock and oscillator gating switch on the edge of each full halt or wake, even a halt that master clear keeps from setting the sleep flag
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      OSC_DRV_EN   <= 1'b1;
      INSTR_CLK_EN <= 1'b1;
      SLEEPING     <= 1'b0;
    end
    else if (CLK_EN)
    begin
      OSC_DRV_EN   <= !(sleep && !wake_any) && !halt_full;
      INSTR_CLK_EN <= !(sleep && !wake_any) && !halt_full;
      SLEEPING     <= (sleep && !wake_any) || halt_full;
    end
  end

  // status flags: power-on sets both, halt clears pd and sets to
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
      flags <= '{power_down_flag: SWC_PD_RESET, timeout_flag: SWC_TO_RESET};
    else if (CLK_EN)
    begin
      if (POR)
        flags <= '{power_down_flag: SWC_PD_RESET,
                   timeout_flag: SWC_TO_RESET};
      else if (wto_evt)
        flags.timeout_flag <= 1'b0;
      else if (halt_full)
      begin
        flags.power_down_flag <= 1'b0;
        flags.timeout_flag    <= 1'b1;
      end
      else if (WDCLR_EXEC)
        flags <= '{power_down_flag: 1'b1, timeout_flag: 1'b1};
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      POWER_DOWN_FLAG <= SWC_PD_RESET;
      TIMEOUT_FLAG    <= SWC_TO_RESET;
    end
    else if (CLK_EN)
    begin
      POWER_DOWN_FLAG <= flags.power_down_flag;
      TIMEOUT_FLAG    <= flags.timeout_flag;
    end
  end

  // watchdog clear pulses: clear instruction, full halt and every wake
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      WDOG_CLEAR     <= 1'b0;
      PRESCALE_CLEAR <= 1'b0;
    end
    else if (CLK_EN)
    begin
      // count cleared but watchdog keeps its clock through sleep
      WDOG_CLEAR     <= (halt_full && WDOG_ENABLE) || WDCLR_EXEC
                        || wake_any;
      PRESCALE_CLEAR <= (halt_full || WDCLR_EXEC || wake_any)
                        && PSA_TO_WDOG;
    end
  end

  // resets: master clear always resets; time-out resets only when awake
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      DEV_RESET       <= 1'b0;
      MASTER_CLEAR_PIN_DRIVE_OE_N <= 1'b1;
    end
    else if (CLK_EN)
    begin
      DEV_RESET       <= master_clear_pin_low || (wto_evt && !sleep);
      MASTER_CLEAR_PIN_DRIVE_OE_N <= 1'b1;
    end
  end

  // resume and vector requests to the core
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      core_req <= '0;
      pend_vec <= 1'b0;
    end
    else if (CLK_EN)
    begin
      core_req.dev_reset <= 1'b0;
      core_req.resume    <= sleep && !master_clear_pin_low
                            && (wake_irq || wto_evt);
      // vector only after the prefetched instruction has executed
      core_req.vector    <= pend_vec;
      pend_vec           <= sleep && !master_clear_pin_low && wake_irq
                            && GLOBAL_IRQ_ENABLE;
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      RESUME      <= 1'b0;
      VECTOR_REQ  <= 1'b0;
      VECTOR_ADDR <= SWC_IRQ_VECTOR;
    end
    else if (CLK_EN)
    begin
      RESUME      <= core_req.resume;
      VECTOR_REQ  <= core_req.vector;
      VECTOR_ADDR <= SWC_IRQ_VECTOR;
    end
  end

  // prefetch address captured on the halt
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
      PREFETCH_ADDR <= '0;
    else if (CLK_EN && HALT_EXEC && !sleep)
      PREFETCH_ADDR <= HALT_PC + 13'h0001;
  end

  // pin drive: follow the core while awake, freeze while asleep
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      PIN_OUT  <= '0;
      PIN_OE_N <= 8'hFF;
    end
    else if (CLK_EN && !(sleep && !wake_any) && !halt_full)
    begin
      PIN_OUT  <= PORT_OUT;
      PIN_OE_N <= PORT_OE_N;
    end
  end

  // cause of the most recent wake, for the core's diagnostics
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
      WAKE_CAUSE <= SWC_CAUSE_NONE;
    else if (CLK_EN && wake_any)
    begin
      case (1'b1)
        master_clear_pin_low: WAKE_CAUSE <= SWC_CAUSE_MASTER_CLEAR_PIN;
        wto_evt:  WAKE_CAUSE <= SWC_CAUSE_WDOG;
        default:  WAKE_CAUSE <= SWC_CAUSE_IRQ;
      endcase
    end
  end

  // assertions
  // a full halt that no flag event of higher priority overrides
  sequence halt_taken_s;
    CLK_EN && halt_full && !POR && !wto_evt;
  endsequence

  // interrupt wake while asleep, master clear not overriding it
  sequence irq_wake_s;
    CLK_EN && wake_irq && !master_clear_pin_low;
  endsequence

  // the same wake with global interrupts on, so a vector must follow
  sequence vec_wake_s;
    CLK_EN && wake_irq && !master_clear_pin_low && GLOBAL_IRQ_ENABLE;
  endsequence

  halt_flags_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    halt_taken_s |=> (CLK_EN && !POR && !wto_evt && !WDCLR_EXEC) |-> ##1
    (!POWER_DOWN_FLAG && TIMEOUT_FLAG)) else $error("halt flags");
  halt_nop_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    CLK_EN && halt_nop |=> !sleep) else $error("nop halt slept");
  osc_off_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    CLK_EN && halt_full && !master_clear_pin_low |=> !OSC_DRV_EN && !INSTR_CLK_EN)
    else $error("osc left on");
  master_clear_pin_hold_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    MASTER_CLEAR_PIN_DRIVE_OE_N) else $error("master_clear_pin driven");
  master_clear_pin_reset_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    CLK_EN && master_clear_pin_low |=> DEV_RESET) else $error("no reset");
  wdog_wake_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    CLK_EN && sleep && wto_evt && !master_clear_pin_low |=> !DEV_RESET && !sleep)
    else $error("wdog wake reset");
  wake_clear_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    CLK_EN && wake_any |=> WDOG_CLEAR) else $error("no wd clear");
  vec_order_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    VECTOR_REQ |-> !RESUME) else $error("vector with resume");
  novec_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    CLK_EN && wake_irq && !GLOBAL_IRQ_ENABLE |=> !pend_vec)
    else $error("vector with global off");
  pin_hold_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    CLK_EN && sleep && !wake_any |=> $stable(PIN_OE_N) && $stable(PIN_OUT))
    else $error("pins moved in sleep");

  // the halt clears the watchdog count whenever the watchdog is on
  halt_wdclr_a: assert property (
    @(posedge CORE_CLK) disable iff (SRST)
    CLK_EN && halt_full && WDOG_ENABLE |=> WDOG_CLEAR)
    else $error("halt left watchdog");
  prefetch_addr_a: assert property (
    @(posedge CORE_CLK) disable iff (SRST)
    CLK_EN && HALT_EXEC && !sleep |=>
    PREFETCH_ADDR == $past(HALT_PC) + 13'h0001)
    else $error("prefetch address");

  // resume sits two stages and vector three stages behind the wake, so the enable
  // must hold through those stages before the request can show
  irq_resume_a: assert property (
    @(posedge CORE_CLK) disable iff (SRST)
    irq_wake_s ##1 CLK_EN |=> RESUME)
    else $error("no resume after wake");
  irq_vector_a: assert property (
    @(posedge CORE_CLK) disable iff (SRST)
    vec_wake_s ##1 CLK_EN ##1 CLK_EN |=> VECTOR_REQ)
    else $error("no vector after wake");

endmodule : swc_ctrl

// File: hw/swc_pkg.sv
/*
  swc_pkg: shared constants and carrier types for the sleep and wake-up
  controller.  Assumes a single core clock domain at 40 MHz.
*/
package swc_pkg;

  // number of wake-capable interrupt sources
  localparam int SWC_NSRC = 6;

  // source positions inside the enable and flag vectors
  localparam int SWC_SRC_ASYNC_TMR = 0;
  localparam int SWC_SRC_CAPTURE   = 1;
  localparam int SWC_SRC_RC_ADC    = 2;
  localparam int SWC_SRC_COMPARE   = 3;
  localparam int SWC_SRC_PIN_CHG   = 4;
  localparam int SWC_SRC_EXT_IRQ   = 5;

  // interrupt vector address
  localparam logic [12:0] SWC_IRQ_VECTOR = 13'h0004;

  // flag values after power-up
  localparam logic SWC_PD_RESET = 1'b1;
  localparam logic SWC_TO_RESET = 1'b1;

  // width of the master clear low-pulse filter, in cycles
  localparam int SWC_MASTER_CLEAR_PIN_FILT = 2;

  // wake cause encoding
  typedef enum logic [1:0] {
    SWC_CAUSE_NONE,
    SWC_CAUSE_MASTER_CLEAR_PIN,
    SWC_CAUSE_WDOG,
    SWC_CAUSE_IRQ
  } swc_cause_t;

  // status flags carried together
  typedef struct packed {
    logic power_down_flag;
    logic timeout_flag;
  } swc_flags_t;

  // core action requests carried together
  typedef struct packed {
    logic resume;
    logic vector;
    logic dev_reset;
  } swc_core_t;

endpackage : swc_pkg

// File: tb/sleep_wakeup_controller_tb_top.sv
/*
  sleep_wakeup_controller_tb_top: self-checking bench for swc_ctrl with
  the core model as partner.  Assumes the package types and a 40 MHz
  clock; inputs change only at falling edges.
*/
`timescale 1ns/1ps
module sleep_wakeup_controller_tb_top;
  import swc_pkg::*;
  // inputs (enable, source, global enable) beside expected wake and vector
  typedef struct packed {logic en; logic [2:0] src; logic global_irq_enable; logic wake;
    logic vec;} swc_row_t;
  logic       CORE_CLK = 1'h0, SRST = 1'h1, CLK_EN = 1'h1, POR = 1'h0;
  logic       WDOG_ENABLE = 1'h1, PSA_TO_WDOG = 1'h1, WDOG_TIMEOUT = 1'h0;
  logic       MASTER_CLEAR_PIN_N = 1'h1, GLOBAL_IRQ_ENABLE = 1'h0;
  logic [5:0] IRQ_ENABLE = 6'h00, IRQ_FLAG = 6'h00;
  logic [7:0] PORT_OUT = 8'hA5, PORT_OE_N = 8'h0F, held;
  logic       HALT_EXEC, WDCLR_EXEC, POWER_DOWN_FLAG, TIMEOUT_FLAG, SLEEPING;
  logic       OSC_DRV_EN, INSTR_CLK_EN, WDOG_CLEAR, PRESCALE_CLEAR;
  logic       DEV_RESET, MASTER_CLEAR_PIN_DRIVE_OE_N, RESUME, VECTOR_REQ;
  logic [12:0] HALT_PC, VECTOR_ADDR, PREFETCH_ADDR;
  logic [7:0] PIN_OUT, PIN_OE_N;
  swc_cause_t WAKE_CAUSE;
  int         num_errors = 0, tests_run = 0, i, n;
  // every source once, global enable both ways; last row is not enabled
  swc_row_t   rows[7] = '{'{1'h1, 3'h0, 1'h0, 1'h1, 1'h0},
    '{1'h1, 3'h1, 1'h1, 1'h1, 1'h1}, '{1'h1, 3'h2, 1'h0, 1'h1, 1'h0},
    '{1'h1, 3'h3, 1'h1, 1'h1, 1'h1}, '{1'h1, 3'h4, 1'h0, 1'h1, 1'h0},
    '{1'h1, 3'h5, 1'h1, 1'h1, 1'h1}, '{1'h0, 3'h2, 1'h1, 1'h0, 1'h0}};

  swc_ctrl i_dut (.CORE_CLK, .SRST, .CLK_EN, .POR, .HALT_EXEC, .WDCLR_EXEC,
    .WDOG_ENABLE, .PSA_TO_WDOG, .WDOG_TIMEOUT, .MASTER_CLEAR_PIN_N,
    .GLOBAL_IRQ_ENABLE, .IRQ_ENABLE, .IRQ_FLAG, .HALT_PC, .PORT_OUT,
    .PORT_OE_N, .POWER_DOWN_FLAG, .TIMEOUT_FLAG, .SLEEPING, .OSC_DRV_EN,
    .INSTR_CLK_EN, .WDOG_CLEAR, .PRESCALE_CLEAR, .DEV_RESET,
    .MASTER_CLEAR_PIN_DRIVE_OE_N, .RESUME, .VECTOR_REQ, .VECTOR_ADDR, .PREFETCH_ADDR,
    .PIN_OUT, .PIN_OE_N, .WAKE_CAUSE);
  swc_core_model i_core (.CORE_CLK, .SRST, .RESUME, .VECTOR_REQ,
    .VECTOR_ADDR, .HALT_EXEC, .WDCLR_EXEC, .HALT_PC);

  // 25 ns period
  initial
    forever #12.5 CORE_CLK = ~CORE_CLK;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(negedge CORE_CLK);
  endtask : cyc

  task automatic print_verdict;
    $display("errors %0d, comparisons %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict

  // the whole run is about 110 cycles; this cuts a hang short
  initial
  begin
    #20000;
    num_errors++;
    print_verdict();
  end

  initial
  begin
    cyc(16);
    SRST = 1'h0;
    chk(POWER_DOWN_FLAG, 1'h1);
    chk(PIN_OE_N, 8'hFF);
    chk(OSC_DRV_EN, 1'h1);
    cyc(2);
    // enabled flag already pending: halt must do nothing
    IRQ_ENABLE = 6'h01;
    IRQ_FLAG = 6'h01;
    i_core.do_halt();
    chk(SLEEPING, 1'h0);
    chk(WDOG_CLEAR, 1'h0);
    cyc(1);
    chk(POWER_DOWN_FLAG, 1'h1);
    IRQ_FLAG = 6'h00;
    // table of interrupt wakes
    for (i = 0; i < 7; i++)
    begin
      IRQ_ENABLE = 6'h00;
      IRQ_ENABLE[rows[i].src] = rows[i].en;
      GLOBAL_IRQ_ENABLE = rows[i].global_irq_enable;
      held = PORT_OUT;
      i_core.do_halt();
      chk(SLEEPING, 1'h1);
      chk(OSC_DRV_EN, 1'h0);
      chk(INSTR_CLK_EN, 1'h0);
      chk(WDOG_CLEAR, 1'h1);
      chk(PREFETCH_ADDR, HALT_PC + 13'h0001);
      PORT_OUT = ~PORT_OUT;
      PORT_OE_N = 8'hF0;
      cyc(1);
      chk(POWER_DOWN_FLAG, 1'h0);
      chk(TIMEOUT_FLAG, 1'h1);
      chk(PIN_OUT, held);
      chk(PIN_OE_N, 8'h0F);
      PORT_OE_N = 8'h0F;
      IRQ_FLAG[rows[i].src] = 1'h1;
      // resume comes out through two register stages, vector through three
      cyc(1);
      chk(SLEEPING, !rows[i].wake);
      chk(WDOG_CLEAR, rows[i].wake);
      if (rows[i].wake)
        chk(WAKE_CAUSE, SWC_CAUSE_IRQ);
      cyc(1);
      chk(RESUME, rows[i].wake);
      cyc(1);
      chk(VECTOR_REQ, rows[i].vec);
      chk(RESUME, 1'h0);
      chk(VECTOR_ADDR, SWC_IRQ_VECTOR);
      IRQ_FLAG = 6'h00;
    end
    // still asleep from the last row: watchdog time-out wakes
    WDOG_TIMEOUT = 1'h1;
    for (n = 0; n < 10 && SLEEPING !== 1'h0; n++)
      cyc(1);
    chk(SLEEPING, 1'h0);
    chk(WDOG_CLEAR, 1'h1);
    chk(DEV_RESET, 1'h0);
    chk(WAKE_CAUSE, SWC_CAUSE_WDOG);
    chk(MASTER_CLEAR_PIN_DRIVE_OE_N, 1'h1);
    cyc(1);
    chk(RESUME, 1'h1);
    chk(VECTOR_REQ, 1'h0);
    cyc(1);
    chk(TIMEOUT_FLAG, 1'h0);
    WDOG_TIMEOUT = 1'h0;
    cyc(3);
    i_core.do_clear();
    chk(WDOG_CLEAR, 1'h1);
    chk(PRESCALE_CLEAR, 1'h1);
    // time-out while awake resets, pin stays undriven
    WDOG_TIMEOUT = 1'h1;
    for (n = 0; n < 10 && DEV_RESET !== 1'h1; n++)
      cyc(1);
    chk(DEV_RESET, 1'h1);
    chk(MASTER_CLEAR_PIN_DRIVE_OE_N, 1'h1);
    chk(SLEEPING, 1'h0);
    WDOG_TIMEOUT = 1'h0;
    cyc(4);
    // master clear during sleep gives a full reset, not a resume
    i_core.do_halt();
    MASTER_CLEAR_PIN_N = 1'h0;
    for (n = 0; n < 10 && DEV_RESET !== 1'h1; n++)
      cyc(1);
    chk(DEV_RESET, 1'h1);
    chk(RESUME, 1'h0);
    chk(WAKE_CAUSE, SWC_CAUSE_MASTER_CLEAR_PIN);
    MASTER_CLEAR_PIN_N = 1'h1;
    cyc(3);
    // second reset in mid-run
    SRST = 1'h1;
    cyc(2);
    SRST = 1'h0;
    chk(POWER_DOWN_FLAG, 1'h1);
    chk(SLEEPING, 1'h0);
    chk(PIN_OE_N, 8'hFF);
    cyc(2);
    // prescaler not assigned: the halt clears only the watchdog count
    PSA_TO_WDOG = 1'h0;
    i_core.do_halt();
    chk(WDOG_CLEAR, 1'h1);
    chk(PRESCALE_CLEAR, 1'h0);
    cyc(1);
    chk(POWER_DOWN_FLAG, 1'h0);
    // power-up event sets the power-down flag again
    POR = 1'h1;
    cyc(1);
    POR = 1'h0;
    cyc(1);
    chk(POWER_DOWN_FLAG, 1'h1);
    // clock enable low freezes a pending wake until it returns
    IRQ_ENABLE = 6'h20;
    IRQ_FLAG = 6'h20;
    CLK_EN = 1'h0;
    cyc(2);
    chk(SLEEPING, 1'h1);
    CLK_EN = 1'h1;
    cyc(1);
    chk(SLEEPING, 1'h0);
    IRQ_FLAG = 6'h00;
    cyc(2);
    print_verdict();
  end
endmodule : sleep_wakeup_controller_tb_top

// File: tb/swc_core_model.sv
/*
  swc_core_model: behavioural stand-in for the processor core beside the
  sleep controller.  Issues clear and halt instructions on request and
  follows resume and vector requests with its program counter.  Assumes
  CORE_CLK and SRST are shared with the controller.
*/
`timescale 1ns/1ps
module swc_core_model
  import swc_pkg::*;
(
  input  wire logic        CORE_CLK,
  input  wire logic        SRST,
  input  wire logic        RESUME,
  input  wire logic        VECTOR_REQ,
  input  wire logic [12:0] VECTOR_ADDR,
  output logic             HALT_EXEC,
  output logic             WDCLR_EXEC,
  output logic [12:0]      HALT_PC
);
  // known levels from time zero, the controller samples them at once;
  // the program counter gets its start value from the held reset
  initial
  begin
    HALT_EXEC  = 1'h0;
    WDCLR_EXEC = 1'h0;
  end

  // program counter steps on resume, jumps on vector request
  always @(posedge CORE_CLK)
  begin
    if (SRST)
      HALT_PC <= 13'h0100;
    else if (VECTOR_REQ)
      HALT_PC <= VECTOR_ADDR;
    else if (RESUME)
      HALT_PC <= HALT_PC + 13'h0001;
  end

  // one-cycle clear instruction, changed only at falling edges
  task automatic do_clear;
    @(negedge CORE_CLK) WDCLR_EXEC = 1'h1;
    @(negedge CORE_CLK) WDCLR_EXEC = 1'h0;
  endtask : do_clear

  // software clears the watchdog right before every halt
  task automatic do_halt;
    do_clear();
    HALT_EXEC = 1'h1;
    @(negedge CORE_CLK) HALT_EXEC = 1'h0;
  endtask : do_halt
endmodule : swc_core_model
